// file: src/srb_burst.sv
`timescale 1ns/1ns
`include "srb_defs.svh"
module srb_burst (
   // Clock and reset
   input  wire logic  ref_clk,
   input  wire logic  reset,
   // Burst length in beats and latency
   input  wire logic [3:0] burst_len,
   input  wire logic [1:0] read_lat,
   // Command side
   srb_burst_if.trk   bif
);
   logic [3:0] left_r;
   logic [3:0] age_r;
   logic       ap_r;
   logic       bank_r;
   logic       single_r;

   // Interruptions at odd ages are refused since columns pair up.
   wire ok_intr = bif.intr && !age_r[0] && !ap_r;
   wire take    = bif.start && (left_r == 4'h0 || ok_intr);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         left_r <= 4'h0;
         age_r  <= 4'h0;
         ap_r   <= 1'b0;
         bank_r <= 1'b0;
      end else if (take) begin
         left_r <= burst_len - 4'h1;
         age_r  <= 4'h1;
         ap_r   <= bif.autopre;
         bank_r <= bif.bank;
      end else if (bif.stop && left_r != 4'h0 && !ap_r && !age_r[0]) begin
         left_r <= 4'h0;
      end else if (left_r != 4'h0) begin
         left_r <= left_r - 4'h1;
         age_r  <= age_r + 4'h1;
      end
   end

   // A single-beat burst never counts down, so its close needs a flag.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         single_r <= 1'b0;
      end else begin
         single_r <= take && bif.autopre && burst_len == 4'h1;
      end
   end

   assign bif.active    = (left_r != 4'h0);
   assign bif.done_pre  = (ap_r && (left_r == 4'h1)) || single_r;
   assign bif.done_bank = bank_r;
   // Lead is a two's complement count against the last data cycle, so the
   // late single-beat case and the two-early case both fit in two bits.
   assign bif.lead = (burst_len == 4'h1) ? 2'h2 - read_lat :
                     2'h1 - read_lat;

   a_stop_ends: assert property (@(posedge ref_clk) disable iff (reset)
      (bif.stop && left_r != 4'h0 && !ap_r && !age_r[0] && !bif.start)
      |=> left_r == 4'h0)
      else $error("burst stop did not end burst");
   a_odd_refused: assert property (@(posedge ref_clk)
      disable iff (reset) (bif.start && left_r > 4'h1 && age_r[0])
      |=> left_r == $past(left_r) - 4'h1)
      else $error("odd cycle interruption accepted");
endmodule : srb_burst

// file: src/srb_burst_if.sv
`timescale 1ns/1ns
interface srb_burst_if;
   logic       start;
   logic       autopre;
   logic       bank;
   logic       intr;
   logic       stop;
   logic       active;
   logic       done_pre;
   logic       done_bank;
   logic [1:0] lead;
   modport ctl (output start, autopre, bank, intr, stop,
                input active, done_pre, done_bank, lead);
   modport trk (input start, autopre, bank, intr, stop,
                output active, done_pre, done_bank, lead);
endinterface : srb_burst_if

// file: src/srb_defs.svh
`ifndef SRB_DEFS_SVH
`define SRB_DEFS_SVH
`define SRB_ROWS_PER_BANK   2048
`define SRB_ROW_CNT_W       12
`define SRB_AP_BIT          10
`define SRB_BANK_BIT        11
`define SRB_ROW_CYCLE_NS    130
`define SRB_CLK_NS          20
`define SRB_ROW_CYCLE_CYC   ((`SRB_ROW_CYCLE_NS+`SRB_CLK_NS-1)/`SRB_CLK_NS)
`define SRB_SELF_REF_NS     15600
`define SRB_SELF_REF_CYC    (`SRB_SELF_REF_NS/`SRB_CLK_NS)
`define SRB_CCD_CYC         2
`endif

// file: src/srb_pkg.sv
package srb_pkg;
   typedef enum logic [2:0] {
      SRB_NOP, SRB_ACT, SRB_RD, SRB_WR, SRB_PRE, SRB_REF, SRB_STOP, SRB_MRS
   } srb_cmd_t;
   typedef enum {SRB_IDLE, SRB_REFRESH, SRB_SELF, SRB_EXIT} srb_state_t;
endpackage : srb_pkg

// file: src/srb_top.sv
`timescale 1ns/1ns
`include "srb_defs.svh"
module srb_top (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // Command pins
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        write_enable_n,
   input  wire logic [11:0] addr,
   // Mode settings
   input  wire logic [3:0]  burst_len,
   input  wire logic [1:0]  read_lat,
   // Status
   output logic [1:0]       bank_open,
   output logic [11:0]      refresh_row,
   output logic             refresh_busy,
   output logic             self_refresh,
   output logic             burst_active,
   output logic [1:0]       precharge_lead
);
   logic [1:0]  pin_s1_r, pin_s2_r;
   logic [16:0] cmd_s1_r, cmd_s2_r;
   srb_pkg::srb_state_t state_r;
   logic [11:0] row_r;
   logic [13:0] tmr_r;
   logic [1:0]  open_r;
   srb_burst_if bif ();

   always_ff @(posedge ref_clk) begin
      pin_s1_r <= {cke, cs_n};
      pin_s2_r <= pin_s1_r;
      cmd_s1_r <= {ras_n, cas_n, write_enable_n, addr, 2'b00};
      cmd_s2_r <= cmd_s1_r;
   end

   wire       ck   = pin_s2_r[1];
   wire       sel  = !pin_s2_r[0];
   wire [2:0] rcw  = cmd_s2_r[16:14];
   wire [11:0] a   = cmd_s2_r[13:2];
   wire       run  = (state_r == srb_pkg::SRB_IDLE) && ck && sel;
   wire       is_act  = run && rcw == 3'b011;
   wire       is_rd   = run && rcw == 3'b101;
   wire       is_wr   = run && rcw == 3'b100;
   wire       is_pre  = run && rcw == 3'b010;
   wire       is_stop = run && rcw == 3'b110;
   wire       is_ref  = (state_r == srb_pkg::SRB_IDLE) && ck && sel
                        && rcw == 3'b001;

   assign bif.start   = is_rd || is_wr;
   assign bif.intr    = (is_rd || is_wr) && bif.active;
   assign bif.autopre = a[`SRB_AP_BIT];
   assign bif.bank    = a[`SRB_BANK_BIT];
   assign bif.stop    = is_stop;

   srb_burst u_burst (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .burst_len (burst_len),
      .read_lat  (read_lat),
      .bif       (bif)
   );

   // Self refresh entry is taken from clock enable low with the
   // refresh code; the address is never looked at for refresh.
   wire self_entry = (state_r == srb_pkg::SRB_IDLE) && !ck && sel
                     && rcw == 3'b001;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_r <= srb_pkg::SRB_IDLE;
         tmr_r   <= 14'h0000;
         row_r   <= 12'h000;
      end else begin
         case (state_r)
            srb_pkg::SRB_IDLE: begin
               if (is_ref) begin
                  state_r <= srb_pkg::SRB_REFRESH;
                  tmr_r   <= 14'(`SRB_ROW_CYCLE_CYC - 1);
                  row_r   <= row_r + 12'h001;
               end else if (self_entry) begin
                  state_r <= srb_pkg::SRB_SELF;
                  tmr_r   <= 14'(`SRB_SELF_REF_CYC - 1);
               end
            end
            srb_pkg::SRB_REFRESH: begin
               if (tmr_r == 14'h0000) begin
                  state_r <= srb_pkg::SRB_IDLE;
               end else begin
                  tmr_r <= tmr_r - 14'h0001;
               end
            end
            srb_pkg::SRB_SELF: begin
               if (ck) begin
                  state_r <= srb_pkg::SRB_EXIT;
                  tmr_r   <= 14'(`SRB_ROW_CYCLE_CYC - 1);
               end else if (tmr_r == 14'h0000) begin
                  tmr_r <= 14'(`SRB_SELF_REF_CYC - 1);
                  row_r <= row_r + 12'h001;
               end else begin
                  tmr_r <= tmr_r - 14'h0001;
               end
            end
            default: begin
               if (tmr_r == 14'h0000) begin
                  state_r <= srb_pkg::SRB_IDLE;
               end else begin
                  tmr_r <= tmr_r - 14'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         open_r <= 2'b00;
      end else if (is_ref || state_r == srb_pkg::SRB_REFRESH) begin
         open_r <= 2'b00;
      end else if (is_pre && a[`SRB_AP_BIT]) begin
         open_r <= 2'b00;
      end else begin
         // An automatic close of one bank must not be lost to a command
         // for the other bank in the same cycle; an activate comes last.
         if (bif.done_pre) begin
            open_r[bif.done_bank] <= 1'b0;
         end
         if (is_pre) begin
            open_r[a[`SRB_BANK_BIT]] <= 1'b0;
         end
         if (is_act) begin
            open_r[a[`SRB_BANK_BIT]] <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bank_open      <= 2'b00;
         refresh_row    <= 12'h000;
         refresh_busy   <= 1'b0;
         self_refresh   <= 1'b0;
         burst_active   <= 1'b0;
         precharge_lead <= 2'b00;
      end else begin
         bank_open      <= open_r;
         refresh_row    <= row_r;
         refresh_busy   <= state_r != srb_pkg::SRB_IDLE;
         self_refresh   <= state_r == srb_pkg::SRB_SELF;
         burst_active   <= bif.active;
         precharge_lead <= bif.lead;
      end
   end

   a_ref_row_step: assert property (@(posedge ref_clk)
      disable iff (reset) is_ref |=> row_r == $past(row_r) + 12'h001)
      else $error("refresh row did not advance");
   a_ref_closes: assert property (@(posedge ref_clk) disable iff (reset)
      is_ref |=> ##[1:8] (state_r == srb_pkg::SRB_IDLE && open_r == 2'b00))
      else $error("refresh did not close banks");
   a_self_hold: assert property (@(posedge ref_clk) disable iff (reset)
      (state_r == srb_pkg::SRB_SELF && !ck) |=> state_r == srb_pkg::SRB_SELF)
      else $error("self refresh left without clock enable");
   a_pre_all: assert property (@(posedge ref_clk) disable iff (reset)
      (is_pre && a[`SRB_AP_BIT] && !is_ref) |=> open_r == 2'b00)
      else $error("precharge all left a bank open");
endmodule : srb_top

// file: test/srb_ctl_model.sv
`timescale 1ns/1ns
module srb_ctl_model (
   // Clock
   input  wire logic        ref_clk,
   // Requests from the bench
   input  wire logic        go,
   input  wire logic [2:0]  code,
   input  wire logic [11:0] a,
   input  wire logic        cke_req,
   // Command pins
   output logic             cke,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             write_enable_n,
   output logic [11:0]      addr
);
   logic        g;
   logic        k;
   logic [2:0]  c;
   logic [11:0] ad;
   initial begin
      cke = 1'b1;
      cs_n = 1'b1;
      {ras_n, cas_n, write_enable_n} = 3'h7;
      addr = 12'h000;
   end
   // Idle address shows the inverse of the last value, so a stale bus never
   // passes for a held command.
   always @(posedge ref_clk) begin
      g = go;
      k = cke_req;
      c = code;
      ad = a;
      #2;
      cke <= k;
      cs_n <= !g;
      {ras_n, cas_n, write_enable_n} <= g ? c : 3'h7;
      addr <= g ? ad : ~addr;
   end
endmodule : srb_ctl_model

// file: test/tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
$display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        go = 1'b0;
   logic        cke_req = 1'b1;
   logic [2:0]  code = 3'h7;
   logic [11:0] a = 12'h000;
   logic [3:0]  burst_len = 4'h8;
   logic [1:0]  read_lat = 2'h3;
   logic        cke, cs_n, ras_n, cas_n, write_enable_n;
   logic [11:0] addr, refresh_row, exp_row;
   logic [11:0] row_prev = 12'h000;
   logic [1:0]  bank_open, precharge_lead;
   logic        refresh_busy, self_refresh, burst_active;
   logic [31:0] seed = 32'hc25e_b2ab;
   logic [3:0]  bl_tab [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
   // Signed lead per latency 1 to 3: single-beat row, then longer bursts.
   logic [1:0]  lead_tab [2][3] = '{'{2'h1, 2'h0, 2'h3}, '{2'h0, 2'h3, 2'h2}};
   logic [11:0] exp_q [$];
   int          fails = 0;
   int          total_checks = 0;
   always #10 ref_clk = ~ref_clk;
   srb_ctl_model srb_ctl_model_i (.ref_clk(ref_clk), .go(go), .code(code),
      .a(a), .cke_req(cke_req), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .write_enable_n(write_enable_n), .addr(addr));
   srb_top srb_top_i (.ref_clk(ref_clk), .reset(reset), .cke(cke),
      .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .write_enable_n(write_enable_n), .addr(addr), .burst_len(burst_len),
      .read_lat(read_lat), .bank_open(bank_open), .refresh_row(refresh_row),
      .refresh_busy(refresh_busy), .self_refresh(self_refresh),
      .burst_active(burst_active), .precharge_lead(precharge_lead));
   always @(negedge ref_clk) begin
      if (!reset && refresh_row !== row_prev) begin
         exp_row = (exp_q.size() > 0) ? exp_q.pop_front() : row_prev;
         `CHK("refresh_row", exp_row, refresh_row)
      end
      row_prev <= refresh_row;
   end
   function logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task test_done;
      if (fails == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   task cmd(input logic [2:0] c, input logic [11:0] ad);
      @(posedge ref_clk);
      #2;
      go = 1'b1;
      code = c;
      a = ad;
   endtask : cmd
   task idle(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         #2;
         go = 1'b0;
      end
   endtask : idle
   // A refresh that never ends must not hang the run.
   task wait_idle;
      for (int k = 0; refresh_busy !== 1'b0; k++) begin
         if (k == 60) begin
            fails++;
            test_done();
         end
         idle(1);
      end
   endtask : wait_idle
   initial begin
      repeat (20) @(posedge ref_clk);
      #2;
      reset = 1'b0;
      idle(4);
      `CHK("reset_row", 12'h000, refresh_row)
      cmd(3'h2, 12'h400);
      idle(3);
      for (int i = 0; i < 3; i++) begin
         seed = lfsr_next(seed);
         exp_q.push_back(12'(i + 1));
         cmd(3'h1, seed[11:0]);
         idle(5);
         `CHK("refresh_busy", 1'b1, refresh_busy)
         wait_idle();
         `CHK("banks_closed", 2'h0, bank_open)
      end
      cmd(3'h3, 12'h000);
      cmd(3'h3, 12'h800);
      idle(5);
      `CHK("both_open", 2'h3, bank_open)
      cmd(3'h2, 12'h800);
      idle(5);
      `CHK("one_closed", 2'h1, bank_open)
      cmd(3'h5, 12'h000);
      cmd(3'h6, 12'h000);
      idle(7);
      `CHK("odd_stop", 1'b1, burst_active)
      idle(8);
      cmd(3'h5, 12'h000);
      idle(1);
      cmd(3'h6, 12'h000);
      idle(7);
      `CHK("even_stop", 1'b0, burst_active)
      cmd(3'h5, 12'h400);
      idle(16);
      `CHK("auto_close", 2'h0, bank_open)
      cmd(3'h1, 12'h000);
      cke_req = 1'b0;
      idle(5);
      `CHK("self_on", 1'b1, self_refresh)
      cmd(3'h3, 12'h800);
      idle(5);
      `CHK("self_ignore", 2'h0, bank_open)
      cke_req = 1'b1;
      idle(5);
      `CHK("self_off", 1'b0, self_refresh)
      wait_idle();
      foreach (bl_tab[i]) begin
         for (int l = 1; l < 4; l++) begin
            burst_len = bl_tab[i];
            read_lat = 2'(l);
            idle(4);
            `CHK("lead", lead_tab[i != 0][l - 1], precharge_lead)
         end
      end
      `CHK("rows_left", 0, exp_q.size())
      test_done();
   end
endmodule : tb
